// ---- hdl/slw_supervisor.sv ----
`timescale 1ns/1ps
`include "slw_params.svh"

// Function
// - Logic runs only while wake is high; otherwise enter sleep.
// - No serial read data while the logic supply is absent.
// - While reset input is low, clock pin is an input; status latches its level.
// - Awake with reset input inactive: drive clock pin high.
// - Sleep, or woken by reset input: clock pin undriven, an input.
// - Both supplies lost: power off, outputs off, registers cleared.
// - Battery lost, logic supply kept: keep registers, channels off.
// - Battery lost, logic supply kept: aux output follows configuration.
// - During battery loss no wake-up event on the clock pin.
// - PWM clock failed: sense sync at default period near 6.5 ms.
module slw_supervisor (
  input wire logic clk,
  input wire logic srst,
  input wire logic bat_por_ok,
  input wire logic vcc_por_ok,
  input wire logic wake_req,
  input wire logic wake_reset_input_n,
  input wire logic clk_pin_in,
  input wire logic pwm_clk_in,
  input wire logic cfg_we,
  input wire slw_pkg::slw_ch_t cfg_ch,
  input wire logic cfg_aux,
  input wire logic rd_req,
  input wire logic [15:0] rd_data_in,
  output logic clk_pin_out,
  output logic clk_pin_oe,
  output slw_pkg::slw_ch_t power_channel_outputs,
  output logic aux_driver_output,
  output logic sense_sync_output_n,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output slw_pkg::slw_state_t supply_state,
  output logic clk_pin_status
);
  import slw_pkg::*;

  localparam int SYNC_CYC = `SLW_SYNC_CYC;
  localparam int SYNC_LOW = `SLW_SYNC_LOW_CYC;
  localparam int PWM_TO = `SLW_PWM_TIMEOUT_CYC;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] bat_s_r, vcc_s_r, wake_s_r, rstn_s_r, pin_s_r, pwm_s_r;
  logic pwm_d_r;

  // Two stages on the supply, wake, reset, clock pin and PWM inputs before any logic reads them.
  always_ff @(posedge clk) begin
    bat_s_r <= {bat_s_r[0], bat_por_ok};
    vcc_s_r <= {vcc_s_r[0], vcc_por_ok};
    wake_s_r <= {wake_s_r[0], wake_req};
    rstn_s_r <= {rstn_s_r[0], wake_reset_input_n};
    pin_s_r <= {pin_s_r[0], clk_pin_in};
    pwm_s_r <= {pwm_s_r[0], pwm_clk_in};
    pwm_d_r <= pwm_s_r[1];
  end

  wire bat_ok = bat_s_r[1];
  wire vcc_ok = vcc_s_r[1];
  wire wake_in = wake_s_r[1];
  wire rst_low = ~rstn_s_r[1];
  wire pwm_edge = pwm_s_r[1] & ~pwm_d_r;

  // ---------------------------------------------------------------
  // Supply state machine
  // ---------------------------------------------------------------
  slw_state_t state_r, state_nxt;
  logic rst_woke_r;
  slw_ch_t ch_cfg_r;
  logic aux_cfg_r;

  // Power-off wins over everything; battery loss with logic supply
  // retained parks in the retain state.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SLW_OFF: begin
        if (bat_ok)
          state_nxt = SLW_SLEEP;
      end
      SLW_SLEEP: begin
        if (wake_in)
          state_nxt = SLW_AWAKE;
      end
      SLW_AWAKE: begin
        if (!wake_in)
          state_nxt = SLW_SLEEP;
      end
      SLW_RETAIN: begin
        if (bat_ok)
          state_nxt = wake_in ? SLW_AWAKE : SLW_SLEEP;
      end
    endcase
    if (!bat_ok && !vcc_ok)
      state_nxt = SLW_OFF;
    else if (!bat_ok)
      state_nxt = SLW_RETAIN;
  end

  // State register; every input it decodes is already synchronised.
  always_ff @(posedge clk) begin
    if (srst)
      state_r <= SLW_OFF;
    else
      state_r <= state_nxt;
  end

  // Remember whether the wake came from the reset input being low.
  always_ff @(posedge clk) begin
    if (srst)
      rst_woke_r <= 1'b0;
    else if (state_r == SLW_SLEEP && state_nxt == SLW_AWAKE)
      rst_woke_r <= rst_low;
    else if (state_r != SLW_AWAKE)
      rst_woke_r <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Held configuration
  // ---------------------------------------------------------------
  // Clear on entering power-off. Writes land only while awake with both
  // supplies present, so a write racing a battery drop is refused.
  wire cfg_clear = (state_nxt == SLW_OFF);
  wire cfg_take = cfg_we & (state_r == SLW_AWAKE) & bat_ok & vcc_ok;

  // Configuration store, cleared by reset or by power-off.
  // defaults after off
  always_ff @(posedge clk) begin
    if (srst || cfg_clear) begin
      ch_cfg_r <= `SLW_CH_RST;
      aux_cfg_r <= `SLW_AUX_RST;
    end else if (cfg_take) begin
      ch_cfg_r <= cfg_ch;
      aux_cfg_r <= cfg_aux;
    end
  end

  // ---------------------------------------------------------------
  // Output drivers
  // ---------------------------------------------------------------
  // Outputs follow the next state so that a supply loss cuts them at once.
  wire chan_run = (state_nxt == SLW_AWAKE);
  wire aux_run = (state_nxt == SLW_AWAKE) | (state_nxt == SLW_RETAIN);
  wire pin_drive = chan_run & ~rst_low & ~rst_woke_r;

  // Registered drivers for the channels, the aux output and the pin.
  // channels off
  always_ff @(posedge clk) begin
    if (srst) begin
      power_channel_outputs <= `SLW_CH_RST;
      aux_driver_output <= `SLW_AUX_RST;
      clk_pin_out <= 1'b0;
      clk_pin_oe <= 1'b0;
    end else begin
      power_channel_outputs <= chan_run ? ch_cfg_r : `SLW_CH_RST;
      aux_driver_output <= aux_run & aux_cfg_r & vcc_ok;
      clk_pin_out <= pin_drive;
      clk_pin_oe <= pin_drive;
    end
  end

  // Latch the pin level while the controller holds the reset input low.
  // status while low
  always_ff @(posedge clk) begin
    if (srst)
      clk_pin_status <= 1'b0;
    else if (rst_low)
      clk_pin_status <= pin_s_r[1];
  end

  // Registered copy of the supply state for the outside.
  always_ff @(posedge clk) begin
    if (srst)
      supply_state <= SLW_OFF;
    else
      supply_state <= state_r;
  end

  // ---------------------------------------------------------------
  // Serial read gate
  // ---------------------------------------------------------------
  // no read unpowered
  wire rd_ok = rd_req & vcc_ok & (state_r != SLW_OFF);

  // Read data stands one cycle and reads as zero when refused.
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_valid <= 1'b0;
      rd_data <= 16'h0000;
    end else begin
      rd_valid <= rd_ok;
      rd_data <= rd_ok ? rd_data_in : 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // PWM clock watchdog and default sense sync
  // ---------------------------------------------------------------
  logic [12:0] pwm_cnt_r;
  logic pwm_fail_r;
  logic [17:0] sync_cnt_r;

  // Count cycles without a PWM clock edge while awake and flag a failed
  // clock at the limit. An edge or leaving the awake state clears it.
  always_ff @(posedge clk) begin
    if (srst || pwm_edge || state_r != SLW_AWAKE) begin
      pwm_cnt_r <= 13'h0000;
      pwm_fail_r <= 1'b0;
    end else if (pwm_cnt_r == 13'(PWM_TO - 1)) begin
      pwm_fail_r <= 1'b1;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 13'h0001;
    end
  end

  wire sync_wrap = (sync_cnt_r == 18'(SYNC_CYC - 1));

  // Default period counter, running only while the PWM clock is failed.
  always_ff @(posedge clk) begin
    if (srst || !pwm_fail_r)
      sync_cnt_r <= 18'h00000;
    else if (sync_wrap)
      sync_cnt_r <= 18'h00000;
    else
      sync_cnt_r <= sync_cnt_r + 18'h00001;
  end

  // Strobe low for the first cycles of every default period.
  always_ff @(posedge clk) begin
    if (srst)
      sense_sync_output_n <= 1'b1;
    else
      sense_sync_output_n <= ~(pwm_fail_r && sync_cnt_r < 18'(SYNC_LOW));
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_OFF_CLEARS: assert property (@(posedge clk) disable iff (srst)
    (!bat_ok && !vcc_ok) |=> (ch_cfg_r == 4'h0) && !aux_cfg_r)
    else $error("Config not cleared on total supply loss.");
  AST_CH_OFF_LOSS: assert property (@(posedge clk) disable iff (srst)
    !bat_ok |=> power_channel_outputs == 4'h0)
    else $error("Channels on during battery loss.");
  AST_KEEP_CFG: assert property (@(posedge clk) disable iff (srst)
    (!bat_ok && vcc_ok) |=> $stable(ch_cfg_r))
    else $error("Config lost while logic supply held.");
  AST_AUX_RETAIN: assert property (@(posedge clk) disable iff (srst)
    (state_nxt == SLW_RETAIN && vcc_ok) |=>
      aux_driver_output == $past(aux_cfg_r))
    else $error("Aux output not following config in retain.");
  AST_NO_WAKE_LOSS: assert property (@(posedge clk) disable iff (srst)
    !bat_ok |=> !clk_pin_oe)
    else $error("Clock pin driven during battery loss.");
  AST_PIN_HIGH: assert property (@(posedge clk) disable iff (srst)
    clk_pin_oe |-> clk_pin_out)
    else $error("Clock pin driven low.");
  AST_PIN_INPUT: assert property (@(posedge clk) disable iff (srst)
    (state_nxt == SLW_SLEEP) |=> !clk_pin_oe)
    else $error("Clock pin driven in sleep.");
  AST_SLEEP_OFF: assert property (@(posedge clk) disable iff (srst)
    (state_nxt != SLW_AWAKE) |=> power_channel_outputs == 4'h0)
    else $error("Channels on while asleep.");
  AST_NO_READ: assert property (@(posedge clk) disable iff (srst)
    !vcc_ok |=> !rd_valid)
    else $error("Read data without logic supply.");
  AST_SYNC_LOW: assert property (@(posedge clk) disable iff (srst)
    (pwm_fail_r && sync_wrap) |=> ##1 !sense_sync_output_n [*8])
    else $error("Default sync strobe missing.");
  AST_RST_WAKE: assert property (@(posedge clk) disable iff (srst)
    rst_low |=> !clk_pin_oe || $past(state_r) == SLW_AWAKE)
    else $error("Pin driven while not awake.");
  AST_OFF_OUTS: assert property (@(posedge clk) disable iff (srst)
    (state_r == SLW_OFF) |=>
      (power_channel_outputs == 4'h0) && !aux_driver_output)
    else $error("Outputs on in power-off.");
  AST_RST_WOKE_IN: assert property (@(posedge clk) disable iff (srst)
    rst_woke_r |=> !clk_pin_oe)
    else $error("Clock pin driven after a wake by the reset input.");
  AST_SYNC_START: assert property (@(posedge clk) disable iff (srst)
    $rose(pwm_fail_r) |=> !sense_sync_output_n)
    else $error("Default sync strobe late after PWM clock failure.");

  // ---------------------------------------------------------------
  // Cover points
  // ---------------------------------------------------------------
  COV_RETAIN: cover property (@(posedge clk) state_r == SLW_RETAIN);
  COV_OFF: cover property (@(posedge clk) disable iff (srst)
    state_r == SLW_AWAKE ##1 state_r == SLW_OFF);
  COV_PIN: cover property (@(posedge clk) clk_pin_oe);
  COV_SYNC: cover property (@(posedge clk) !sense_sync_output_n);
  COV_RST_WOKE: cover property (@(posedge clk) rst_woke_r);

endmodule // slw_supervisor

// ---- include/slw_params.svh ----
`ifndef SLW_PARAMS_SVH
`define SLW_PARAMS_SVH

// Clock rate of the internal oscillator in kHz.
`define SLW_CLK_KHZ 20000
// Default sense sync period in microseconds: least, nominal, longest.
`define SLW_SYNC_MIN_US 4800
`define SLW_SYNC_NOM_US 6500
`define SLW_SYNC_MAX_US 8200
// Nominal period in cycles, derived from the rate.
`define SLW_SYNC_CYC ((`SLW_SYNC_NOM_US * `SLW_CLK_KHZ) / 1000)
// Low pulse width of the sync strobe in cycles.
`define SLW_SYNC_LOW_CYC 20
// Cycles without a PWM clock edge before it counts as failed.
`define SLW_PWM_TIMEOUT_CYC 4000
// Reset values of the held configuration.
`define SLW_CH_RST 4'h0
`define SLW_AUX_RST 1'b0
`define SLW_CH_N 4

`endif

// ---- include/slw_pkg.sv ----
package slw_pkg;
  // Supply state of the device.
  typedef enum logic [1:0] {
    SLW_OFF,
    SLW_SLEEP,
    SLW_AWAKE,
    SLW_RETAIN
  } slw_state_t;
  typedef logic [3:0] slw_ch_t;
endpackage

// ---- verification/slw_mcu_model.sv ----
`timescale 1ns/1ps
// --------------------------------------------------
// External controller on the reset and clock pins
// --------------------------------------------------
module slw_mcu_model (
  input wire logic clk,
  input wire logic hold_rst,
  input wire logic drv,
  input wire logic drv_val,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic wake_reset_input_n,
  output logic pin_level
);
  logic last_r = 1'b0;
  logic driven;
  logic drive_val;
  // The controller holds the reset pin low on request.
  assign wake_reset_input_n = ~hold_rst;
  // Either side may drive the pin; the device takes precedence.
  assign driven = pin_oe | drv;
  assign drive_val = pin_oe ? pin_out : drv_val;
  // pin read back
  // A floating pin shows the inverse of its last driven level.
  assign pin_level = driven ? drive_val : ~last_r;
  // Remember the last driven level for the floating case.
  always @(posedge clk) begin
    if (driven) begin
      last_r <= drive_val;
    end
  end
endmodule // slw_mcu_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`include "slw_params.svh"
module tb_top;
  import slw_pkg::*;
  logic clk, srst, bat, vcc, wake, hold, drv, dv, pwm, pwm_en, we, aux, rd;
  logic pout, poe, lvl, rstn, auxo, sn, rdv, stat;
  slw_ch_t ch, pch;
  logic [15:0] rdi, rdo;
  slw_state_t st;
  int miscompares, tests_run, cycles;
  // --------------------------------------------------
  // Design and partner
  // --------------------------------------------------
  slw_supervisor dut_u (.clk(clk), .srst(srst), .bat_por_ok(bat),
    .vcc_por_ok(vcc), .wake_req(wake), .wake_reset_input_n(rstn),
    .clk_pin_in(lvl), .pwm_clk_in(pwm), .cfg_we(we), .cfg_ch(ch),
    .cfg_aux(aux), .rd_req(rd), .rd_data_in(rdi), .clk_pin_out(pout),
    .clk_pin_oe(poe), .power_channel_outputs(pch),
    .aux_driver_output(auxo), .sense_sync_output_n(sn), .rd_valid(rdv),
    .rd_data(rdo), .supply_state(st), .clk_pin_status(stat));
  slw_mcu_model mcu_u (.clk(clk), .hold_rst(hold), .drv(drv),
    .drv_val(dv), .pin_out(pout), .pin_oe(poe),
    .wake_reset_input_n(rstn), .pin_level(lvl));
  // Clock, PWM clock and hang guard.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(negedge clk) begin
    if (pwm_en && cycles % 4 == 0) pwm <= ~pwm;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  // --------------------------------------------------
  // Helpers
  // --------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic read(output logic v, output logic [15:0] d);
    v = 1'b0;
    d = 16'h0;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    repeat (3) begin
      if (rdv === 1'b1) begin
        v = 1'b1;
        d = rdo;
      end
      cyc(1);
    end
  endtask
  // --------------------------------------------------
  // Scenarios
  // --------------------------------------------------
  task automatic t_reset_values;
    chk("rst_state", 16'(st), 16'(SLW_OFF));
    chk("rst_sync", 16'(sn), 16'h1);
  endtask
  task automatic t_wake_config;
    bat = 1'b1;
    vcc = 1'b1;
    wake = 1'b1;
    cyc(8);
    chk("awake", 16'(st), 16'(SLW_AWAKE));
    chk("pin_drv", 16'({poe, pout}), 16'h3);
    ch = 4'hA;
    aux = 1'b1;
    we = 1'b1;
    cyc(1);
    we = 1'b0;
    cyc(3);
    chk("cfg_ch", 16'(pch), 16'hA);
    chk("cfg_aux", 16'(auxo), 16'h1);
  endtask
  task automatic t_read_gate;
    logic v;
    logic [15:0] d;
    rdi = 16'h5A3C;
    read(v, d);
    chk("rd_data", d, 16'h5A3C);
    vcc = 1'b0;
    cyc(6);
    read(v, d);
    chk("rd_refused", 16'(v), 16'h0);
    vcc = 1'b1;
    cyc(6);
  endtask
  task automatic t_battery_loss;
    bat = 1'b0;
    cyc(8);
    chk("retain", 16'(st), 16'(SLW_RETAIN));
    chk("ret_ch", 16'({pch, auxo}), 16'h1);
    chk("ret_pin", 16'(poe), 16'h0);
    // A write while retained is refused; the kept setup must come back.
    ch = 4'h5;
    aux = 1'b0;
    we = 1'b1;
    cyc(1);
    we = 1'b0;
    bat = 1'b1;
    cyc(8);
    chk("kept_cfg", 16'({pch, auxo}), 16'h15);
    bat = 1'b0;
    cyc(8);
    vcc = 1'b0;
    cyc(8);
    chk("off", 16'({st, pch, auxo}), 16'h0);
    bat = 1'b1;
    vcc = 1'b1;
    cyc(8);
    chk("reawake", 16'({st, pch, auxo}), {9'h000, SLW_AWAKE, 5'h00});
  endtask
  task automatic t_reset_pin;
    hold = 1'b1;
    drv = 1'b1;
    dv = 1'b1;
    cyc(8);
    chk("rst_pin_oe", 16'(poe), 16'h0);
    chk("stat_hi", 16'(stat), 16'h1);
    dv = 1'b0;
    cyc(6);
    chk("stat_lo", 16'(stat), 16'h0);
    hold = 1'b0;
    drv = 1'b0;
    wake = 1'b0;
    cyc(8);
    chk("sleep", 16'({st, poe}), {13'h0, SLW_SLEEP, 1'b0});
  endtask
  task automatic t_reset_wake;
    hold = 1'b1;
    wake = 1'b1;
    cyc(8);
    chk("rwake_state", 16'(st), 16'(SLW_AWAKE));
    hold = 1'b0;
    cyc(8);
    chk("rwake_oe", 16'(poe), 16'h0);
    wake = 1'b0;
    cyc(8);
    wake = 1'b1;
    cyc(8);
    chk("wake_oe", 16'({poe, pout}), 16'h3);
  endtask
  task automatic t_pwm_fail;
    int n;
    pwm_en = 1'b0;
    n = 0;
    while (sn !== 1'b0 && n < 4300) begin
      n++;
      cyc(1);
    end
    chk("sync_seen", 16'(sn), 16'h0);
    n = 0;
    while (sn === 1'b0 && n < 100) begin
      n++;
      cyc(1);
    end
    chk("sync_width", 16'(n), 16'(`SLW_SYNC_LOW_CYC));
  endtask
  task automatic tally_and_finish;
    $display("Checks made %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence: reset three cycles, then scenarios.
  initial begin
    {srst, bat, vcc, wake, hold, drv, dv, pwm, we, aux, rd} = 11'h400;
    pwm_en = 1'b1;
    ch = 4'h0;
    rdi = 16'h0000;
    miscompares = 0;
    tests_run = 0;
    cycles = 0;
    cyc(3);
    srst = 1'b0;
    cyc(2);
    t_reset_values;
    t_wake_config;
    t_read_gate;
    t_battery_loss;
    t_reset_pin;
    t_reset_wake;
    t_pwm_fail;
    tally_and_finish;
  end
endmodule // tb_top
